//--- src/cfs_pkg.sv
// constants and register map of the left-to-right character field scan unit
package cfs_pkg;
  localparam int CHAR_W   = 6;
  localparam int WORD_W   = 24;
  localparam int CAW      = 20;
  localparam int WAW      = 18;
  localparam int IDX_W    = 15;
  localparam int LEN_W    = 12;
  localparam int CPW      = 4;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_OPERAND = 8'h04;
  localparam logic [7:0] OFF_ADDR    = 8'h08;
  localparam logic [7:0] OFF_IDX1    = 8'h0c;
  localparam logic [7:0] OFF_IDX2    = 8'h10;
  localparam logic [7:0] OFF_IDX3    = 8'h14;
  localparam logic [7:0] OFF_PADDR   = 8'h18;
  localparam logic [7:0] OFF_STATUS  = 8'h1c;
  localparam logic [7:0] OFF_NEXT    = 8'h20;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_NE_BIT    = 1;
  localparam int CTRL_DELIM_BIT = 2;
  localparam int OPR_SCAN_LSB   = 0;
  localparam int OPR_DELIM_LSB  = 6;
  localparam int OPR_LEN_LSB    = 12;
  localparam int ADDR_R_LSB     = 0;
  localparam int ADDR_FLAG_LSB  = 20;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_FIND_BIT    = 1;
  localparam int ST_DEXIT_BIT   = 2;
  localparam int ST_COND_LSB    = 4;

  localparam logic [WAW-1:0] NEXT_MISS_OFS = 18'h00003;
  localparam logic [WAW-1:0] NEXT_FIND_OFS = 18'h00004;
  localparam logic [1:0]     COND_CLEAR    = 2'h0;
  localparam logic [1:0]     AXI_OKAY      = 2'h0;
  localparam logic [1:0]     AXI_SLVERR    = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_SCAN} cfs_state_t;
endpackage : cfs_pkg

//--- src/cfs_char_cmp.sv
// six-bit character comparator
`timescale 1ns/100ps
module cfs_char_cmp
  import cfs_pkg::*;
(
  input  wire logic [CHAR_W-1:0] i_field_char,
  input  wire logic [CHAR_W-1:0] i_ref_char,
  output logic                   o_equal
);
  // exact code compare: 12, 32 and 52 octal never alias the zero character
  assign o_equal = (i_field_char == i_ref_char); // RULE11 RULE14
endmodule : cfs_char_cmp

//--- src/cfs_eff_addr.sv
// indexed effective character address
`timescale 1ns/100ps
module cfs_eff_addr
  import cfs_pkg::*;
(
  input  wire logic [CAW-1:0]   i_base_addr,
  input  wire logic [1:0]       i_index_select_flag,
  input  wire logic [IDX_W-1:0] i_first_index_reg,
  input  wire logic [IDX_W-1:0] i_second_index_reg,
  output logic      [CAW-1:0]   o_eff_addr
);
  logic [IDX_W-1:0] index;

  always_comb begin
    unique case (i_index_select_flag)
      2'h1, 2'h3: index = i_first_index_reg; // RULE2
      2'h2:       index = i_second_index_reg; // RULE2
      2'h0:       index = '0; // RULE2
    endcase
  end

  // index treated as unsigned; the sum wraps in the character space
  assign o_eff_addr = i_base_addr + CAW'(index);
endmodule : cfs_eff_addr

//--- src/cfs_scan_unit.sv
// left-to-right character field scan unit with axi4-lite registers
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Overview of operation
// RULE1 - compare 6-bit characters one by one from address R upward, at most length
// RULE2 - start address is r plus index: flag 1/3 first, 2 second, 0 none
// RULE3 - equality search: match exits at P+4, no match over field exits P+3
// RULE4 - inequality search: first differing character exits P+4, all equal exits P+3
// RULE5 - delimited forms: delimiter match ends search, exits P+3
// RULE6 - delimited equality: scan match wins over identical delimiter, exits P+4
// RULE7 - delimited inequality: scan and delimit find together exit P+4
// RULE8 - on a find, characters searched go to low 12 bits of count index
// RULE9 - without a find, count index low field takes the full search length; a delimiter exit stores the characters searched instead
// RULE10 - upper 3 bits of count index are left undefined by the search
// RULE11 - codes 12, 32, 52 octal never equal the zero character
// RULE12 - condition register is cleared to 00 at completion
// RULE13 - software zeroes reserved instruction bits; not checked here
// RULE14 - scan character held as 6-bit operand, compared directly with each character
// RULE15 - storage word fetched only on word crossing; no fetch after search ends
module cfs_scan_unit
  import cfs_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_b,
  input  wire logic [7:0]        i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [7:0]        i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic                   o_mem_req,
  output logic [WAW-1:0]         o_mem_addr,
  input  wire logic              i_mem_ack,
  input  wire logic [WORD_W-1:0] i_mem_rdata
);

  // one record for all state keeps reset and the register step in one place
  typedef struct packed {
    cfs_state_t        state;
    logic [7:0]        awaddr;
    logic              aw_have;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              w_have;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              match_unequal_mode;
    logic              delim_mode;
    logic [CHAR_W-1:0] scan_char;
    logic [CHAR_W-1:0] delimit_char;
    logic [LEN_W-1:0]  search_length;
    logic [CAW-1:0]    base_addr;
    logic [1:0]        index_select_flag;
    logic [IDX_W-1:0]  first_index_reg;
    logic [IDX_W-1:0]  second_index_reg;
    logic [IDX_W-1:0]  count_index_reg;
    logic [WAW-1:0]    opcode_addr;
    logic [WAW-1:0]    next_addr;
    logic [1:0]        cond;
    logic              found;
    logic              delim_exit;
    logic [CAW-1:0]    char_ptr;
    logic [LEN_W-1:0]  count;
    logic [WORD_W-1:0] word;
    logic              mem_req;
  } cfs_regs_t;

  cfs_regs_t q;
  cfs_regs_t d;

  logic [CAW-1:0]    eff_addr;
  logic [CHAR_W-1:0] cur_char;
  logic              eq_scan;
  logic              eq_delim;
  logic [32:0]       rd_view;
  logic [32:0]       wr_view;
  logic              word_last;
  logic [LEN_W-1:0]  count_inc;
  logic              scan_find;

  // start address is taken only at start; later index writes leave a running search alone
  cfs_eff_addr u_eff_addr (
    .i_base_addr         (q.base_addr),
    .i_index_select_flag (q.index_select_flag),
    .i_first_index_reg   (q.first_index_reg),
    .i_second_index_reg  (q.second_index_reg),
    .o_eff_addr          (eff_addr)
  );

  // leftmost character of a word sits in the top six bits
  assign cur_char = CHAR_W'(q.word >> (CHAR_W * (CPW - 1 - int'(q.char_ptr[1:0]))));

  // rightmost character of the held word: the next one needs a fresh fetch
  assign word_last = (q.char_ptr[1:0] == 2'(CPW - 1));
  assign count_inc = q.count + LEN_W'(1);

  cfs_char_cmp u_cmp_scan (
    .i_field_char (cur_char),
    .i_ref_char   (q.scan_char),
    .o_equal      (eq_scan)
  );

  cfs_char_cmp u_cmp_delim (
    .i_field_char (cur_char),
    .i_ref_char   (q.delimit_char),
    .o_equal      (eq_delim)
  );

  // inequality mode inverts only the scan compare, never the delimiter compare
  assign scan_find = q.match_unequal_mode ? !eq_scan : eq_scan; // RULE3 RULE4

  // returns {error, data} for one register offset
  function automatic logic [32:0] reg_view(input logic [7:0] addr, input cfs_regs_t s);
    logic [31:0] v;
    logic        err;
    v   = '0;
    err = 1'b0;
    unique case (addr)
      OFF_CTRL: begin
        v[CTRL_NE_BIT]    = s.match_unequal_mode;
        v[CTRL_DELIM_BIT] = s.delim_mode;
      end
      OFF_OPERAND: begin
        v[OPR_SCAN_LSB +: CHAR_W]  = s.scan_char;
        v[OPR_DELIM_LSB +: CHAR_W] = s.delimit_char;
        v[OPR_LEN_LSB +: LEN_W]    = s.search_length;
      end
      OFF_ADDR: begin
        v[ADDR_R_LSB +: CAW]  = s.base_addr;
        v[ADDR_FLAG_LSB +: 2] = s.index_select_flag;
      end
      OFF_IDX1:  v[IDX_W-1:0] = s.first_index_reg;
      OFF_IDX2:  v[IDX_W-1:0] = s.second_index_reg;
      OFF_IDX3:  v[IDX_W-1:0] = s.count_index_reg;
      OFF_PADDR: v[WAW-1:0]   = s.opcode_addr;
      OFF_STATUS: begin
        v[ST_BUSY_BIT]       = (s.state != ST_IDLE);
        v[ST_FIND_BIT]       = s.found;
        v[ST_DEXIT_BIT]      = s.delim_exit;
        v[ST_COND_LSB +: 2]  = s.cond;
      end
      OFF_NEXT:  v[WAW-1:0]   = s.next_addr;
      default:   err = 1'b1;
    endcase
    return {err, v};
  endfunction : reg_view

  // byte strobes lay new bytes over what the register already holds
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // read data reflects the state just before the accepting edge
  assign rd_view = reg_view(i_araddr, q);
  assign wr_view = reg_view(q.awaddr, q);

  always_comb begin
    logic [31:0] wv;
    logic        start;
    logic        hit;
    logic        fin;
    logic        fin_find;
    logic        fin_delim;
    logic [LEN_W-1:0] fin_count;
    wv        = merge(wr_view[31:0], q.wdata, q.wstrb);
    start     = 1'b0;
    hit       = 1'b0;
    fin       = 1'b0;
    fin_find  = 1'b0;
    fin_delim = 1'b0;
    fin_count = q.search_length;
    d         = q;

    // write channel: address and data taken in either order
    if (i_awvalid && q.awready) begin
      d.awaddr  = i_awaddr;
      d.aw_have = 1'b1;
    end
    if (i_wvalid && q.wready) begin
      d.wdata  = i_wdata;
      d.wstrb  = i_wstrb;
      d.w_have = 1'b1;
    end
    if (q.bvalid && i_bready) begin
      d.bvalid = 1'b0;
    end
    // unmapped offsets answer slverr and change nothing; read-only fields ignore writes
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = wr_view[32] ? AXI_SLVERR : AXI_OKAY;
      unique case (q.awaddr)
        OFF_CTRL: begin
          // mode is frozen while a search runs; a start while busy is dropped
          if (q.state == ST_IDLE) begin
            d.match_unequal_mode = wv[CTRL_NE_BIT];
            d.delim_mode         = wv[CTRL_DELIM_BIT];
            start                = q.wstrb[0] && q.wdata[CTRL_START_BIT];
          end
        end
        OFF_OPERAND: begin
          d.scan_char     = wv[OPR_SCAN_LSB +: CHAR_W]; // RULE14
          d.delimit_char  = wv[OPR_DELIM_LSB +: CHAR_W];
          d.search_length = wv[OPR_LEN_LSB +: LEN_W];
        end
        OFF_ADDR: begin
          d.base_addr         = wv[ADDR_R_LSB +: CAW];
          d.index_select_flag = wv[ADDR_FLAG_LSB +: 2];
        end
        OFF_IDX1:   d.first_index_reg  = wv[IDX_W-1:0];
        OFF_IDX2:   d.second_index_reg = wv[IDX_W-1:0];
        OFF_IDX3:   d.count_index_reg  = wv[IDX_W-1:0];
        OFF_PADDR:  d.opcode_addr      = wv[WAW-1:0];
        OFF_STATUS: d.cond             = wv[ST_COND_LSB +: 2];
        default: ;
      endcase
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready  = !d.w_have && !d.bvalid;

    // read channel: one outstanding read, answered the edge after acceptance
    if (q.rvalid && i_rready) begin
      d.rvalid = 1'b0;
    end
    if (i_arvalid && q.arready) begin
      d.rdata  = rd_view[31:0];
      d.rresp  = rd_view[32] ? AXI_SLVERR : AXI_OKAY;
      d.rvalid = 1'b1;
    end
    d.arready = !d.rvalid;

    // search engine
    unique case (q.state)
      ST_IDLE: begin
        if (start) begin
          d.char_ptr   = eff_addr; // RULE2
          d.count      = '0;
          d.found      = 1'b0;
          d.delim_exit = 1'b0;
          // zero length ends at once as a miss, with no storage access
          if (q.search_length == '0) begin
            fin = 1'b1;
          end else begin
            d.state   = ST_FETCH;
            d.mem_req = 1'b1; // RULE15
          end
        end
      end
      ST_FETCH: begin
        // storage may take any number of cycles; the request stands until the answer
        if (i_mem_ack) begin
          d.word    = i_mem_rdata;
          d.mem_req = 1'b0;
          d.state   = ST_SCAN;
        end
      end
      ST_SCAN: begin
        hit = scan_find;
        if (hit) begin
          // scan find takes priority over a delimiter on the same character
          fin       = 1'b1; // RULE6 RULE7
          fin_find  = 1'b1;
          fin_count = q.count; // RULE8
        end else if (q.delim_mode && eq_delim) begin
          fin       = 1'b1; // RULE5
          fin_delim = 1'b1;
          fin_count = q.count;
        end else if (count_inc == q.search_length) begin
          fin = 1'b1; // RULE1 RULE9
        end else begin
          d.count    = count_inc;
          d.char_ptr = q.char_ptr + CAW'(1); // RULE1
          if (word_last) begin
            // next character lies in the following word
            d.state   = ST_FETCH; // RULE15
            d.mem_req = 1'b1;
          end
        end
      end
      default: d.state = ST_IDLE;
    endcase

    if (fin) begin
      d.state      = ST_IDLE;
      d.mem_req    = 1'b0;
      d.found      = fin_find;
      d.delim_exit = fin_delim;
      d.next_addr  = q.opcode_addr + (fin_find ? NEXT_FIND_OFS : NEXT_MISS_OFS); // RULE3 RULE5
      // upper bits simply keep whatever they held
      d.count_index_reg = {q.count_index_reg[IDX_W-1:LEN_W], fin_count}; // RULE8 RULE9 RULE10
      d.cond            = COND_CLEAR; // RULE12
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      // readies come up high so the first request after reset is taken at once
      q         <= '0;
      q.state   <= ST_IDLE;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign o_awready  = q.awready;
  assign o_wready   = q.wready;
  assign o_bvalid   = q.bvalid;
  assign o_bresp    = q.bresp;
  assign o_arready  = q.arready;
  assign o_rvalid   = q.rvalid;
  assign o_rdata    = q.rdata;
  assign o_rresp    = q.rresp;
  assign o_mem_req  = q.mem_req;
  // word address is the character pointer without its in-word index
  assign o_mem_addr = q.char_ptr[CAW-1:2];

endmodule : cfs_scan_unit

//--- sim/cfs_mem_model.sv
// word storage model answering fetch requests of the scan unit
`timescale 1ns/100ps
module cfs_mem_model
  import cfs_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_slow,
  input  wire logic              i_req,
  input  wire logic [WAW-1:0]    i_addr,
  output logic                   o_ack = 1'b0,
  output logic [WORD_W-1:0]      o_rdata = '0
);
  logic [WORD_W-1:0] mem [0:15];
  logic [2:0]        wait_q = 3'h0;
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    // data flips every cycle between answers, so a capture one cycle late shows up
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      wait_q <= wait_q + 3'h1;
      if (!i_slow || wait_q == 3'h3) begin
        o_ack   <= 1'b1;
        o_rdata <= mem[i_addr[3:0]];
        wait_q  <= 3'h0;
      end
    end
  end
endmodule : cfs_mem_model

//--- sim/cfs_scan_unit_chk.sv
// port checker bound to the scan unit
`timescale 1ns/100ps
module cfs_scan_unit_chk
  import cfs_pkg::*;
(
  input wire logic           i_core_clk,
  input wire logic           i_rst_b,
  input wire logic [7:0]     i_awaddr,
  input wire logic           i_awvalid,
  input wire logic           o_awready,
  input wire logic           i_wvalid,
  input wire logic           o_wready,
  input wire logic [1:0]     o_bresp,
  input wire logic           o_bvalid,
  input wire logic           i_bready,
  input wire logic [7:0]     i_araddr,
  input wire logic           i_arvalid,
  input wire logic           o_arready,
  input wire logic [31:0]    o_rdata,
  input wire logic [1:0]     o_rresp,
  input wire logic           o_rvalid,
  input wire logic           i_rready,
  input wire logic           o_mem_req,
  input wire logic [WAW-1:0] o_mem_addr,
  input wire logic           i_mem_ack
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  wire aw_go = i_awvalid && o_awready && i_wvalid && o_wready;
  wire ar_go = i_arvalid && o_arready;
  property p_req_hold; o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr); endproperty
  a_req_hold: assert property (p_req_hold) else $error("fetch dropped");
  property p_req_end; o_mem_req && i_mem_ack |=> !o_mem_req; endproperty
  a_req_end: assert property (p_req_end) else $error("fetch repeated");
  property p_b_ans; aw_go |=> (!o_awready && !o_wready) ##1 o_bvalid; endproperty
  a_b_ans: assert property (p_b_ans) else $error("no write answer");
  property p_b_stand; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  a_b_stand: assert property (p_b_stand) else $error("write answer lost");
  property p_b_err; aw_go && i_awaddr > 8'h20 |-> ##2 o_bresp == AXI_SLVERR; endproperty
  a_b_err: assert property (p_b_err) else $error("unmapped write accepted");
  property p_r_ans; ar_go |=> o_rvalid && !o_arready; endproperty
  a_r_ans: assert property (p_r_ans) else $error("no read answer");
  property p_r_stand; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  a_r_stand: assert property (p_r_stand) else $error("read data lost");
  property p_r_err;
    ar_go && i_araddr > 8'h20 |=> o_rresp == AXI_SLVERR && o_rdata == 32'h0;
  endproperty
  a_r_err: assert property (p_r_err) else $error("unmapped read accepted");
  property p_r_done; o_rvalid && i_rready |=> !o_rvalid && o_arready; endproperty
  a_r_done: assert property (p_r_done) else $error("read not closed");
  c_fetch: cover property (o_mem_req && i_mem_ack);
  c_rerr: cover property (o_rvalid && o_rresp == AXI_SLVERR);
  c_berr: cover property (o_bvalid && o_bresp == AXI_SLVERR);
endmodule : cfs_scan_unit_chk

bind cfs_scan_unit cfs_scan_unit_chk u_chk (.i_core_clk, .i_rst_b, .i_awaddr, .i_awvalid,
  .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
  .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_mem_req, .o_mem_addr, .i_mem_ack);

//--- sim/tb_top.sv
// self-checking bench for the scan unit
`timescale 1ns/100ps
module tb_top import cfs_pkg::*;;
  logic              i_core_clk, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic              i_rst_b = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic              i_arvalid = 1'b0, i_rready = 1'b0, slow = 1'b0, o_mem_req, i_mem_ack;
  logic [7:0]        i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0]       i_wdata = 32'h0, o_rdata, rd;
  logic [3:0]        i_wstrb = 4'hf;
  logic [1:0]        o_bresp, o_rresp, rs;
  logic [WAW-1:0]    o_mem_addr;
  logic [WORD_W-1:0] i_mem_rdata;
  int                err_count = 0, num_checks = 0, cyc = 0;
  cfs_scan_unit u_cfs_scan_unit (.i_core_clk, .i_rst_b, .i_awaddr, .i_awvalid, .o_awready,
    .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_mem_req,
    .o_mem_addr, .i_mem_ack, .i_mem_rdata);
  cfs_mem_model u_cfs_mem_model (.i_clk(i_core_clk), .i_slow(slow), .i_req(o_mem_req),
    .i_addr(o_mem_addr), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge i_core_clk);
    i_awaddr <= a;
    i_wdata <= v;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_core_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
    end while (!(i_bready && o_bvalid));
    r = o_bresp;
    i_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge i_core_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_core_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
    end while (!(i_rready && o_rvalid));
    v = o_rdata;
    r = o_rresp;
    i_rready <= 1'b0;
  endtask : axi_rd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, rd, rs);
    chk(rd, e);
  endtask : rd_chk
  // c is the control word: bit1 unequal mode, bit2 delimited
  task automatic do_scan(input logic [2:0] c, input logic [5:0] sc, dc, input logic [11:0] ln,
      input logic [21:0] ad, input logic f, input logic [11:0] n);
    axi_wr(OFF_OPERAND, {8'h00, ln, dc, sc}, rs);
    axi_wr(OFF_ADDR, {10'h000, ad}, rs);
    axi_wr(OFF_PADDR, 32'h100, rs);
    axi_wr(OFF_STATUS, 32'h30, rs);
    axi_wr(OFF_CTRL, {29'h0, c}, rs);
    rd = 32'h1;
    while (rd[0] === 1'b1) axi_rd(OFF_STATUS, rd, rs);
    chk({31'h0, rd[1]}, {31'h0, f});
    chk({30'h0, rd[5:4]}, {30'h0, COND_CLEAR});
    rd_chk(OFF_NEXT, {14'h0, 18'h100 + (f ? NEXT_FIND_OFS : NEXT_MISS_OFS)});
    axi_rd(OFF_IDX3, rd, rs);
    chk({20'h0, rd[11:0]}, {20'h0, n});
  endtask : do_scan
  task automatic t_regs();
    rd_chk(OFF_STATUS, 32'h0);
    axi_wr(OFF_IDX1, 32'hffffffff, rs);
    rd_chk(OFF_IDX1, 32'h7fff);
    axi_wr(OFF_NEXT, 32'h5, rs);
    rd_chk(OFF_NEXT, 32'h0);
    axi_wr(8'h40, 32'h1, rs);
    chk({30'h0, rs}, {30'h0, AXI_SLVERR});
    axi_rd(8'h44, rd, rs);
    chk({rd[31:2], rs}, {30'h0, AXI_SLVERR});
    // start bit and modes sit in byte 0: without its strobe nothing starts or changes
    i_wstrb <= 4'he;
    axi_wr(OFF_CTRL, 32'h7, rs);
    i_wstrb <= 4'hf;
    rd_chk(OFF_STATUS, 32'h0);
    rd_chk(OFF_CTRL, 32'h0);
  endtask : t_regs
  task automatic t_eq();
    do_scan(3'h1, 6'h04, 6'h00, 12'h008, 22'h0, 1'b1, 12'h3);
    do_scan(3'h1, 6'h00, 6'h00, 12'h003, 22'h4, 1'b0, 12'h3);
    do_scan(3'h1, 6'h00, 6'h00, 12'h004, 22'h4, 1'b1, 12'h3);
    do_scan(3'h1, 6'h09, 6'h00, 12'h008, 22'h5, 1'b1, 12'h6);
    do_scan(3'h1, 6'h04, 6'h00, 12'h000, 22'h0, 1'b0, 12'h0);
  endtask : t_eq
  task automatic t_ne();
    do_scan(3'h3, 6'h05, 6'h00, 12'h008, 22'h8, 1'b1, 12'h3);
    slow <= 1'b1;
    do_scan(3'h3, 6'h05, 6'h00, 12'h008, 22'hc, 1'b0, 12'h8);
  endtask : t_ne
  task automatic t_delim();
    do_scan(3'h5, 6'h09, 6'h00, 12'h008, 22'h5, 1'b0, 12'h2);
    rd_chk(OFF_STATUS, 32'h4);
    do_scan(3'h5, 6'h04, 6'h04, 12'h008, 22'h0, 1'b1, 12'h3);
    do_scan(3'h7, 6'h05, 6'h09, 12'h008, 22'h8, 1'b1, 12'h3);
    do_scan(3'h7, 6'h05, 6'h05, 12'h008, 22'h8, 1'b0, 12'h0);
  endtask : t_delim
  task automatic t_index();
    axi_wr(OFF_IDX1, 32'h4, rs);
    axi_wr(OFF_IDX2, 32'h8, rs);
    for (int i = 0; i < 4; i++) begin
      slow <= i[0];
      do_scan(3'h1, 6'h09, 6'h00, 12'h00c, {i[1:0], 20'h0}, 1'b1,
              (i == 2) ? 12'h3 : (i == 0) ? 12'hb : 12'h7);
    end
  endtask : t_index
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  // a hang in any handshake wait ends here
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    u_cfs_mem_model.mem[0] = 24'h0420c4;
    u_cfs_mem_model.mem[1] = 24'h29aa80;
    u_cfs_mem_model.mem[2] = 24'h145149;
    u_cfs_mem_model.mem[3] = 24'h145145;
    u_cfs_mem_model.mem[4] = 24'h145145;
    repeat (6) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    t_regs();
    t_eq();
    t_ne();
    t_delim();
    t_index();
    stop_test();
  end
endmodule : tb_top
